// ===== bench/rtsp_pin1_monitor.sv
// Assertion checker for the status pin 1 selector
`timescale 1ns/1ps
`default_nettype none
module rtsp_pin1_monitor (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic [7:0] regReadData,
  input wire logic horizLockStd,
  input wire logic horizLockFast,
  input wire logic vertLock,
  input wire logic colourDetected,
  input wire logic lineStart,
  input wire logic fieldOdd,
  input wire logic vertSyncPulse,
  input wire logic rtStatusPin1Out,
  input wire logic rtStatusPin1Oe
);
  logic [3:0] sel;
  logic pol;
  logic fast;
  logic hl;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  assign hl = fast ? horizLockFast : horizLockStd;
  // ----------------------------------------
  // Shadow of select, polarity, lock select
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      sel <= 4'h0;
      pol <= 1'b0;
      fast <= 1'b0;
    end
    else if (regWrite)
    begin
      if (regAddr == 8'h12) sel <= regWriteData[7:4];
      if (regAddr == 8'h11) pol <= regWriteData[6];
      if (regAddr == 8'h13) fast <= regWriteData[3];
    end
  end
  float_code_a: assert property ($past(sel) == 4'h0 |-> !rtStatusPin1Oe)
    else $error("Pin driven with float code");
  low_code_a: assert property ($past(sel) == 4'h1 |-> rtStatusPin1Oe && rtStatusPin1Out == $past(pol))
    else $error("Low code level wrong");
  full_ref_a: assert property ($past(sel) == 4'h2 && $past(sel, 2) == 4'h2 && $past(pol) == $past(pol, 2)
    |-> rtStatusPin1Out != $past(rtStatusPin1Out)) else $error("Full clock ref not toggling");
  half_ref_a: assert property ($past(sel) == 4'h3 && $past(sel, 2) == 4'h3 && $past(sel, 3) == 4'h3
    && $past(pol) == $past(pol, 3) |-> rtStatusPin1Out != $past(rtStatusPin1Out, 2)) else $error("Half ref wrong");
  horiz_lock_a: assert property ($past(sel) == 4'h4 |-> rtStatusPin1Out == ($past(hl) ^ $past(pol)))
    else $error("Lock level wrong");
  both_lock_a: assert property ($past(sel) == 4'h5 |-> rtStatusPin1Out == ($past(hl & vertLock) ^ $past(pol)))
    else $error("Dual lock level wrong");
  full_lock_a: assert property ($past(sel) == 4'h6
    |-> rtStatusPin1Out == ($past(hl & vertLock & colourDetected) ^ $past(pol))) else $error("Full lock level wrong");
  vert_sync_a: assert property ($past(sel) == 4'hC |-> rtStatusPin1Out == ($past(vertSyncPulse) ^ $past(pol)))
    else $error("Vertical sync level wrong");
  reserved_code_a: assert property ($past(sel) inside {4'h7, 4'hB, 4'hE} |-> !rtStatusPin1Oe)
    else $error("Pin driven with reserved code");
endmodule
bind rtsp_pin1_select rtsp_pin1_monitor mon (.*);
`default_nettype wire

// ===== bench/rtsp_pin_sampler.sv
// Back-end sampler model resolving the status pin wire
`timescale 1ns/1ps
`default_nettype none
module rtsp_pin_sampler (
  input wire logic clk_sys,
  input wire logic pinOut,
  input wire logic pinOe,
  output logic pinLevel
);
  logic lastLevel = 1'b0;
  // Released wire shows the inverse of its last driven level
  always_ff @(posedge clk_sys)
  begin
    if (pinOe) lastLevel <= pinOut;
  end
  assign pinLevel = pinOe ? pinOut : ~lastLevel;
endmodule
`default_nettype wire

// ===== bench/rtsp_tb.sv
// Self-checking bench for the status pin 1 selector
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0, reset = 1'b1, regWrite = 1'b0, rdNote = 1'b0, pinNote = 1'b0;
  logic [7:0] regAddr = 8'h00, regWriteData = 8'h00, regReadData;
  logic horizLockStd = 1'b0, horizLockFast = 1'b0, vertLock = 1'b0, colourDetected = 1'b0;
  logic lineStart = 1'b0, fieldOdd = 1'b0, vertSyncPulse = 1'b0;
  logic rtStatusPin1Out, rtStatusPin1Oe, pinLevel, fast;
  logic [4:0] r;
  logic [7:0] regQ[$], wrVal[8];
  logic [1:0] pinQ[$];
  logic [7:0] addrs[8] = '{8'h06, 8'h07, 8'h11, 8'h12, 8'h13, 8'h15, 8'h16, 8'h17};
  logic [3:0] codes[9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC, 4'hE};
  int n_mismatch = 0, checked = 0, seed = 89247, cyc = 0;
  int t0, t1, t2, hor_sync_begin, hor_sync_stop, hor_sync_fine_delay, vert_gate_start, vert_gate_stop, highs;
  rtsp_pin1_select dut (.*);
  rtsp_pin_sampler sampler (.clk_sys(clk_sys), .pinOut(rtStatusPin1Out), .pinOe(rtStatusPin1Oe), .pinLevel(pinLevel));
  initial forever #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ----------------------------------------
  // Drivers, checks and closing report
  // ----------------------------------------
  task automatic note(input string w, input logic [31:0] e, input logic [31:0] s, input bit ok);
    checked++;
    if (!ok)
    begin
      n_mismatch++;
      $display("Error %s expected %0h seen %0h", w, e, s);
    end
  endtask
  task automatic cmpReg(input logic [7:0] e, input logic [7:0] s);
    note("regReadData", e, s, s === e);
  endtask
  task automatic cmpPin(input logic [1:0] e);
    note("pin", e, {rtStatusPin1Oe, pinLevel}, e[1] === rtStatusPin1Oe && (!e[1] || e[0] === pinLevel));
  endtask
  task automatic cmpNum(input string w, input int e, input int s);
    note(w, e, s, e == s);
  endtask
  task complete_run;
    $display("Comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regWrite <= 1'b1;
    regAddr <= a;
    regWriteData <= d;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    regAddr <= a;
    regQ.push_back(e);
    @(posedge clk_sys);
    rdNote <= 1'b1;
    @(posedge clk_sys);
    rdNote <= 1'b0;
  endtask
  task automatic pinChk(input logic [1:0] e);
    @(posedge clk_sys);
    pinQ.push_back(e);
    pinNote <= 1'b1;
    @(posedge clk_sys);
    pinNote <= 1'b0;
  endtask
  task automatic edgeAt(input logic lvl, output int t);
    logic p;
    int k;
    p = rtStatusPin1Out;
    for (k = 0; k < 4000; k++)
    begin
      @(posedge clk_sys);
      #1;
      if (rtStatusPin1Out === lvl && p === ~lvl) break;
      p = rtStatusPin1Out;
    end
    if (k == 4000) n_mismatch++;
    if (k == 4000) complete_run();
    t = cyc;
  endtask
  function automatic logic [1:0] expPin(input logic [3:0] c, input logic p, input logic f, input logic [4:0] v);
    logic h;
    h = f ? v[3] : v[4];
    case (c)
      4'h1: return {1'b1, p};
      4'h4: return {1'b1, h ^ p};
      4'h5: return {1'b1, (h & v[2]) ^ p};
      4'h6: return {1'b1, (h & v[2] & v[1]) ^ p};
      4'hC: return {1'b1, v[0] ^ p};
      default: return 2'b00;
    endcase
  endfunction
  always @(posedge clk_sys)
  begin
    if (rdNote) cmpReg(regQ.pop_front(), regReadData);
    if (pinNote) cmpPin(pinQ.pop_front());
  end
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    foreach (addrs[i])
    begin
      wrVal[i] = 8'($random(seed));
      wr(addrs[i], wrVal[i]);
    end
    wr(8'h14, 8'hA5);
    foreach (addrs[i]) rd(addrs[i], wrVal[i]);
    rd(8'h14, 8'h00);
    foreach (codes[i]) for (int p = 0; p < 2; p++)
    begin
      r = 5'($random(seed));
      fast = 1'($random(seed));
      {horizLockStd, horizLockFast, vertLock, colourDetected, vertSyncPulse} <= r;
      wr(8'h13, {4'h0, fast, 3'h0});
      wr(8'h11, {1'b0, p[0], 6'h00});
      wr(8'h12, {codes[i], 4'h0});
      pinChk(expPin(codes[i], p[0], fast, r));
    end
    wr(8'h12, 8'h20);
    repeat (8) @(posedge clk_sys);
    wr(8'h12, 8'h30);
    repeat (8) @(posedge clk_sys);
    vertSyncPulse <= 1'b1;
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h80);
    edgeAt(1'b0, t0);
    edgeAt(1'b1, t0);
    edgeAt(1'b0, t1);
    cmpNum("line ref width", 1440, t1 - t0);
    edgeAt(1'b1, t2);
    cmpNum("line period", 1728, t2 - t0);
    vertSyncPulse <= 1'b0;
    hor_sync_begin = 10 + $unsigned($random(seed)) % 140;
    hor_sync_stop = hor_sync_begin + 1 + $unsigned($random(seed)) % 40;
    hor_sync_fine_delay = $unsigned($random(seed)) % 4;
    wr(8'h06, 8'(hor_sync_begin));
    wr(8'h07, 8'(hor_sync_stop));
    wr(8'h11, {2'b00, 2'(hor_sync_fine_delay), 4'h0});
    wr(8'h12, 8'h90);
    edgeAt(1'b0, t1);
    edgeAt(1'b1, t1);
    edgeAt(1'b0, t2);
    cmpNum("sync width", (hor_sync_stop - hor_sync_begin) * 8, t2 - t1);
    cmpNum("sync offset", (hor_sync_begin * 8 + hor_sync_fine_delay * 2 - 280 + 1728) % 1728, (t1 - t0) % 1728);
    vert_gate_start = 2 + $unsigned($random(seed)) % 4;
    vert_gate_stop = vert_gate_start + 1 + $unsigned($random(seed)) % 4;
    wr(8'h15, 8'(vert_gate_start));
    wr(8'h16, 8'(vert_gate_stop));
    wr(8'h17, 8'h00);
    wr(8'h12, 8'hD0);
    vertSyncPulse <= 1'b1;
    fieldOdd <= 1'b1;
    repeat (4) @(posedge clk_sys);
    vertSyncPulse <= 1'b0;
    highs = 0;
    repeat (12)
    begin
      repeat (20) @(posedge clk_sys);
      #1;
      highs += int'(rtStatusPin1Out === 1'b1);
      @(posedge clk_sys);
      lineStart <= 1'b1;
      @(posedge clk_sys);
      lineStart <= 1'b0;
    end
    cmpNum("gate lines", vert_gate_stop - vert_gate_start, highs);
    wr(8'h12, 8'hF0);
    pinChk(2'b11);
    wr(8'h12, 8'hA0);
    pinChk(2'b10);
    complete_run();
  end
endmodule
`default_nettype wire

// ===== core/rtsp_line_timer.sv
// Line timing: clock references, active line reference and horizontal sync
`timescale 1ns/1ps
`default_nettype none
`include "rtsp_consts.svh"
module rtsp_line_timer #(
  parameter int LINE_CLOCKS = `RTSP_LINE_CLOCKS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] horSyncBegin,
  input wire logic [7:0] horSyncStop,
  input wire logic [1:0] horSyncFineDelay,
  output logic clockRefFull,
  output logic clockRefHalf,
  output logic activeLineRef,
  output logic horizSyncPulse
);
  localparam int CW = `RTSP_LINE_CLOCKS_W;
  logic [CW-1:0] linePos;
  logic [CW-1:0] hsBeginPos;
  logic [CW-1:0] hsStopPos;
  logic [CW-1:0] activeEnd;
  // ----------------------------------------
  // Line position counter
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset || linePos == CW'(LINE_CLOCKS - 1))
      linePos <= '0;
    else
      linePos <= linePos + 1'b1;
  end
  // ----------------------------------------
  // Clock references
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      clockRefFull <= 1'b0;
      clockRefHalf <= 1'b0;
    end
    else
    begin
      clockRefFull <= ~clockRefFull;
      if (clockRefFull)
        clockRefHalf <= ~clockRefHalf;
    end
  end
  // ----------------------------------------
  // Active line reference and sync
  // ----------------------------------------
  assign activeEnd = `RTSP_ACTIVE_START + CW'(`RTSP_ACTIVE_PIXELS * `RTSP_LLC_PER_PIXEL);
  assign hsBeginPos = CW'({horSyncBegin, 3'b000}) + CW'({horSyncFineDelay, 1'b0});
  assign hsStopPos = CW'({horSyncStop, 3'b000}) + CW'({horSyncFineDelay, 1'b0});
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      activeLineRef <= 1'b0;
      horizSyncPulse <= 1'b0;
    end
    else
    begin
      // Runs on every line, blanking included
      activeLineRef <= (linePos >= `RTSP_ACTIVE_START) && (linePos < activeEnd);
      if (linePos == hsBeginPos)
        horizSyncPulse <= 1'b1;
      else if (linePos == hsStopPos)
        horizSyncPulse <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== core/rtsp_pin1_select.sv
// Status pin 1 source selector with its control registers
//
// What this block does
// - Select field 12h[7:4] picks the source; 0 floats, 1 drives low.
// - Code 2 drives the full-rate 13.5 MHz toggling clock reference.
// - Code 3 drives the half-rate 6.75 MHz toggling clock reference.
// - Code 4 drives horizontal lock: high locked, low unlocked.
// - Code 5 drives high only with vertical and horizontal lock.
// - Code 6 drives high only with both locks and colour detected.
// - Code 8 drives active line reference, high over 720 valid pixels.
// - Active line reference keeps running through vertical blanking.
// - Code 9 drives horizontal sync, begin and stop in eight-clock steps.
// - Horizontal sync shifts by two-clock steps from a 2-bit fine delay.
// - Code 10 drives active line reference ANDed with vertical gate.
// - Code 12 drives vertical sync pulse.
// - Code 13 drives vertical gate from 9-bit start, stop and shift bit.
// - Code 15 drives field identifier placed by the gate start value.
// - Polarity bit inverts whatever source reaches the pin.
// - Lock select bit picks standard or fast horizontal lock indicator.
`timescale 1ns/1ps
`default_nettype none
`include "rtsp_consts.svh"
module rtsp_pin1_select #(
  parameter int LINE_CLOCKS = `RTSP_LINE_CLOCKS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic regWrite,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  input wire logic horizLockStd,
  input wire logic horizLockFast,
  input wire logic vertLock,
  input wire logic colourDetected,
  input wire logic lineStart,
  input wire logic fieldOdd,
  input wire logic vertSyncPulse,
  output logic rtStatusPin1Out,
  output logic rtStatusPin1Oe
);
  logic [7:0] horSyncBeginReg;
  logic [7:0] horSyncStopReg;
  logic [7:0] sigCtrlReg;
  logic [7:0] pinSelectReg;
  logic [7:0] outCtrlReg;
  logic [7:0] vgateStartReg;
  logic [7:0] vgateStopReg;
  logic [7:0] vgateMsbReg;
  logic clockRefFull;
  logic clockRefHalf;
  logic activeLineRef;
  logic horizSyncPulse;
  logic horizLockFlag;
  logic [8:0] vertGateStart;
  logic [8:0] vertGateStop;
  logic [8:0] lineCount;
  logic vertGateWindow;
  logic fieldIdentifier;
  logic next_pinLevel;
  logic next_pinDrive;
  rtsp_pkg::rtsp_sel_t selCode;
  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      horSyncBeginReg <= `RTSP_REG_RESET;
      horSyncStopReg <= `RTSP_REG_RESET;
      sigCtrlReg <= `RTSP_REG_RESET;
      pinSelectReg <= `RTSP_REG_RESET;
      outCtrlReg <= `RTSP_REG_RESET;
      vgateStartReg <= `RTSP_REG_RESET;
      vgateStopReg <= `RTSP_REG_RESET;
      vgateMsbReg <= `RTSP_REG_RESET;
    end
    else if (regWrite)
    begin
      case (regAddr)
        `RTSP_OFS_HSYNC_BEGIN: horSyncBeginReg <= regWriteData;
        `RTSP_OFS_HSYNC_STOP: horSyncStopReg <= regWriteData;
        `RTSP_OFS_SIG_CTRL: sigCtrlReg <= regWriteData;
        `RTSP_OFS_PIN1_SELECT: pinSelectReg <= regWriteData;
        `RTSP_OFS_OUT_CTRL: outCtrlReg <= regWriteData;
        `RTSP_OFS_VERT_GATE_WINDOW_START: vgateStartReg <= regWriteData;
        `RTSP_OFS_VERT_GATE_WINDOW_STOP: vgateStopReg <= regWriteData;
        `RTSP_OFS_VERT_GATE_WINDOW_MSB: vgateMsbReg <= regWriteData;
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Register read back
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      regReadData <= 8'h00;
    else
    begin
      case (regAddr)
        `RTSP_OFS_HSYNC_BEGIN: regReadData <= horSyncBeginReg;
        `RTSP_OFS_HSYNC_STOP: regReadData <= horSyncStopReg;
        `RTSP_OFS_SIG_CTRL: regReadData <= sigCtrlReg;
        `RTSP_OFS_PIN1_SELECT: regReadData <= pinSelectReg;
        `RTSP_OFS_OUT_CTRL: regReadData <= outCtrlReg;
        `RTSP_OFS_VERT_GATE_WINDOW_START: regReadData <= vgateStartReg;
        `RTSP_OFS_VERT_GATE_WINDOW_STOP: regReadData <= vgateStopReg;
        `RTSP_OFS_VERT_GATE_WINDOW_MSB: regReadData <= vgateMsbReg;
        default: regReadData <= 8'h00;
      endcase
    end
  end
  // ----------------------------------------
  // Line timing
  // ----------------------------------------
  rtsp_line_timer #(
    .LINE_CLOCKS(LINE_CLOCKS)
  ) u_line_timer (
    .clk_sys(clk_sys),
    .reset(reset),
    .horSyncBegin(horSyncBeginReg),
    .horSyncStop(horSyncStopReg),
    .horSyncFineDelay(sigCtrlReg[`RTSP_HOR_SYNC_FINE_DELAY_LSB +: 2]),
    .clockRefFull(clockRefFull),
    .clockRefHalf(clockRefHalf),
    .activeLineRef(activeLineRef),
    .horizSyncPulse(horizSyncPulse)
  );
  // ----------------------------------------
  // Vertical gate and field identifier
  // ----------------------------------------
  assign vertGateStart = {vgateMsbReg[`RTSP_VSTA8_BIT], vgateStartReg};
  assign vertGateStop = {vgateMsbReg[`RTSP_VSTO8_BIT], vgateStopReg};
  always_ff @(posedge clk_sys)
  begin
    if (reset || vertSyncPulse)
      lineCount <= 9'h000;
    else if (lineStart)
      lineCount <= lineCount + 9'h001;
  end
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      vertGateWindow <= 1'b0;
      fieldIdentifier <= 1'b0;
    end
    else
    begin
      // Shift bit moves the gate edges one line earlier in the odd field
      if (lineStart && (lineCount + 9'(vgateMsbReg[`RTSP_VERT_GATE_POS_SHIFT_BIT] & fieldOdd)) == vertGateStart)
        vertGateWindow <= 1'b1;
      else if (lineStart && (lineCount + 9'(vgateMsbReg[`RTSP_VERT_GATE_POS_SHIFT_BIT] & fieldOdd)) == vertGateStop)
        vertGateWindow <= 1'b0;
      if (lineStart && lineCount == vertGateStart)
        fieldIdentifier <= fieldOdd;
    end
  end
  // ----------------------------------------
  // Source selection
  // ----------------------------------------
  assign selCode = rtsp_pkg::rtsp_sel_t'(pinSelectReg[`RTSP_SEL_LSB +: 4]);
  assign horizLockFlag = outCtrlReg[`RTSP_LOCKSEL_BIT] ? horizLockFast : horizLockStd;
  always_comb
  begin
    next_pinDrive = 1'b1;
    case (selCode)
      rtsp_pkg::RTSP_SEL_HIZ: begin next_pinLevel = 1'b0; next_pinDrive = 1'b0; end
      rtsp_pkg::RTSP_SEL_LOW: next_pinLevel = 1'b0;
      rtsp_pkg::RTSP_SEL_CLOCK_REF_FULL: next_pinLevel = clockRefFull;
      rtsp_pkg::RTSP_SEL_CLOCK_REF_HALF: next_pinLevel = clockRefHalf;
      rtsp_pkg::RTSP_SEL_HLOCK: next_pinLevel = horizLockFlag;
      rtsp_pkg::RTSP_SEL_VHLOCK: next_pinLevel = horizLockFlag & vertLock;
      rtsp_pkg::RTSP_SEL_FULLLOCK: next_pinLevel = horizLockFlag & vertLock & colourDetected;
      rtsp_pkg::RTSP_SEL_LINEREF: next_pinLevel = activeLineRef;
      rtsp_pkg::RTSP_SEL_HSYNC: next_pinLevel = horizSyncPulse;
      rtsp_pkg::RTSP_SEL_GATEDREF: next_pinLevel = activeLineRef & vertGateWindow;
      rtsp_pkg::RTSP_SEL_VSYNC: next_pinLevel = vertSyncPulse;
      rtsp_pkg::RTSP_SEL_VERT_GATE_WINDOW: next_pinLevel = vertGateWindow;
      rtsp_pkg::RTSP_SEL_FIELD: next_pinLevel = fieldIdentifier;
      default: begin next_pinLevel = 1'b0; next_pinDrive = 1'b0; end
    endcase
  end
  // ----------------------------------------
  // Pin output stage
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      rtStatusPin1Out <= 1'b0;
      rtStatusPin1Oe <= 1'b0;
    end
    else
    begin
      rtStatusPin1Out <= next_pinLevel ^ sigCtrlReg[`RTSP_POL_BIT];
      rtStatusPin1Oe <= next_pinDrive;
    end
  end
endmodule
`default_nettype wire

// ===== inc/rtsp_consts.svh
// Offsets, field positions and timing counts for the status pin 1 selector
`ifndef RTSP_CONSTS_SVH
`define RTSP_CONSTS_SVH
`define RTSP_OFS_HSYNC_BEGIN 8'h06
`define RTSP_OFS_HSYNC_STOP 8'h07
`define RTSP_OFS_SIG_CTRL 8'h11
`define RTSP_OFS_PIN1_SELECT 8'h12
`define RTSP_OFS_OUT_CTRL 8'h13
`define RTSP_OFS_VERT_GATE_WINDOW_START 8'h15
`define RTSP_OFS_VERT_GATE_WINDOW_STOP 8'h16
`define RTSP_OFS_VERT_GATE_WINDOW_MSB 8'h17
`define RTSP_SEL_LSB 4
`define RTSP_POL_BIT 6
`define RTSP_HOR_SYNC_FINE_DELAY_LSB 4
`define RTSP_LOCKSEL_BIT 3
`define RTSP_VSTA8_BIT 0
`define RTSP_VSTO8_BIT 1
`define RTSP_VERT_GATE_POS_SHIFT_BIT 2
`define RTSP_REG_RESET 8'h00
`define RTSP_LLC_PER_PIXEL 2
`define RTSP_ACTIVE_PIXELS 720
`define RTSP_LINE_CLOCKS 1728
`define RTSP_LINE_CLOCKS_W 11
`define RTSP_ACTIVE_START 11'h118
`define RTSP_HSYNC_STEP_SHIFT 3
`define RTSP_HOR_SYNC_FINE_DELAY_STEP_SHIFT 1
`endif

// ===== inc/rtsp_pkg.sv
// Types for the status pin 1 selector
package rtsp_pkg;
  typedef enum logic [3:0] {
    RTSP_SEL_HIZ = 4'h0,
    RTSP_SEL_LOW = 4'h1,
    RTSP_SEL_CLOCK_REF_FULL = 4'h2,
    RTSP_SEL_CLOCK_REF_HALF = 4'h3,
    RTSP_SEL_HLOCK = 4'h4,
    RTSP_SEL_VHLOCK = 4'h5,
    RTSP_SEL_FULLLOCK = 4'h6,
    RTSP_SEL_LINEREF = 4'h8,
    RTSP_SEL_HSYNC = 4'h9,
    RTSP_SEL_GATEDREF = 4'hA,
    RTSP_SEL_VSYNC = 4'hC,
    RTSP_SEL_VERT_GATE_WINDOW = 4'hD,
    RTSP_SEL_FIELD = 4'hF
  } rtsp_sel_t;
endpackage
